// [logic/faif_pkg.sv]
`default_nettype none
package faif_pkg;
    // Special-function register offsets
    localparam logic [7:0]  SFR_PROG_STEER = 8'hB2;
    localparam logic [7:0]  SFR_CORE_PEND  = 8'hC0;
    localparam logic [7:0]  SFR_SRC_FLAGS  = 8'hE8;
    localparam logic [7:0]  SFR_VPULSE     = 8'hF8;
    // External-data register offsets
    localparam logic [15:0] XD_FLASH_CTL   = 16'h2702;
    localparam logic [15:0] XD_RAW_INT     = 16'h2707;
    // Field positions and widths
    localparam int          STEER_BIT      = 0;
    localparam int          TPEND_BIT      = 3;
    localparam int          VPULSE_BIT     = 3;
    localparam int          PEND2_BIT      = 1;
    localparam int          PEND6_BIT      = 5;
    localparam int          WRE_BIT        = 1;
    localparam int          RDE_BIT        = 2;
    localparam int          KEY_LSB        = 4;
    localparam int          KEY_W          = 4;
    localparam int          RAW_W          = 7;
    localparam int          SRC_W          = 8;
    // Values
    localparam logic [3:0]  UNLOCK_KEY     = 4'h2;
    localparam logic [3:0]  KEY_RST        = 4'h0;
    localparam logic        STEER_RST      = 1'b0;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
endpackage : faif_pkg
`default_nettype wire

// [logic/faif_flags.sv]
`timescale 1ns/1ps
`default_nettype none
// Bank of sticky flags; a set in the same cycle as a clear wins
module faif_flags #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] flags_o
);
    logic [WIDTH-1:0] next_flags;

    generate
        genvar g;
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_comb begin
                next_flags[g] = set_i[g] | (flags_o[g] & ~clr_i[g]);
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_o <= '0;
        end else begin
            flags_o <= next_flags;
        end
    end
endmodule : faif_flags
`default_nettype wire

// [logic/faif_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - With the steer bit at 0 an external-data store outside the two register addresses goes to the data RAM; this is the reset state.
// - With the steer bit at 1 an external-data store is written to flash at the pointer address.
// - The steer bit is cleared by hardware after each byte written to flash, unless software sets it in the same cycle.
// - Writes to the steer bit are ignored while interrupts are globally enabled.
// - The read-permission bit is the inverse of the security lock.
// - Flash modification is blocked unless the unlock key field holds 2; the field resets to 0.
// - A read-only bit reports whether debug or serial-slave flash writes are allowed.
// - Each source flag is set by its event and stays set until software clears it.
// - The source flags tell which event drove shared interrupt lines 2, 5 and 6.
// - Core pending bits for interrupts 2 and 6 clear when the core vectors to the handler.
// - The raw interrupt field shows live unlatched levels of inputs 0 to 6.
// - While a timed flash write is pending, further flash writes are ignored.
module faif_regs
    import faif_pkg::*;
#(
    parameter logic [8:0] INT2_MASK = 9'h007,
    parameter logic [8:0] INT5_MASK = 9'h0D0,
    parameter logic [8:0] INT6_MASK = 9'h128
) (
    // Clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        RST_I,
    // Special-function register port
    input  wire logic [7:0]  SFR_ADDR_I,
    input  wire logic [7:0]  SFR_WDATA_I,
    input  wire logic        SFR_WR_I,
    input  wire logic        SFR_RD_I,
    output logic      [7:0]  SFR_RDATA_O,
    // External-data move port (address is the data pointer)
    input  wire logic [15:0] XD_ADDR_I,
    input  wire logic [7:0]  XD_WDATA_I,
    input  wire logic        XD_WR_I,
    input  wire logic        XD_RD_I,
    output logic      [7:0]  XD_RDATA_O,
    // Routed stores
    output logic             XRAM_WR_O,
    output logic             FLASH_WR_O,
    output logic      [15:0] STORE_ADDR_O,
    output logic      [7:0]  STORE_DATA_O,
    // Core and flash status
    input  wire logic        INT_EN_I,
    input  wire logic        VECT2_I,
    input  wire logic        VECT6_I,
    input  wire logic        SECURITY_LOCK_LOCK_I,
    input  wire logic        TIMED_PEND_I,
    // Interrupt sources
    input  wire logic [7:0]  SRC_EVENT_I,
    input  wire logic        VPULSE_EVENT_I,
    input  wire logic [6:0]  RAW_INT_I,
    // Status outputs
    output logic             STEER_O,
    output logic             READ_ALLOWED_O,
    output logic             WRITE_ALLOWED_O,
    output logic             INT2_O,
    output logic             INT5_O,
    output logic             INT6_O,
    output logic             CORE_PEND2_O,
    output logic             CORE_PEND6_O
);
    if ((INT2_MASK & INT5_MASK) != '0 || (INT2_MASK & INT6_MASK) != '0
        || (INT5_MASK & INT6_MASK) != '0) begin : g_mask_check
        $error("interrupt source groups overlap");
    end
    function automatic logic sfr_hit(input logic [7:0] a, input logic [7:0] off);
        sfr_hit = (a == off);
    endfunction : sfr_hit
    ////////////////////////////////////////////////////////////////////////////////
    // Flash steering and unlock
    logic                 steer;
    logic                 next_steer;
    logic [KEY_W-1:0]     unlock_key;
    logic [KEY_W-1:0]     next_unlock_key;
    logic                 key_ok;
    logic                 reg_space;
    logic                 flash_store;
    logic                 xram_store;
    logic                 steer_write;
    assign key_ok      = (unlock_key == UNLOCK_KEY);
    assign reg_space   = (XD_ADDR_I == XD_FLASH_CTL) || (XD_ADDR_I == XD_RAW_INT);
    // Blocked stores are dropped rather than falling through to RAM
    assign flash_store = XD_WR_I && steer && key_ok && !TIMED_PEND_I;
    assign xram_store  = XD_WR_I && !steer && !reg_space;
    assign steer_write = SFR_WR_I && sfr_hit(SFR_ADDR_I, SFR_PROG_STEER) && !INT_EN_I;
    always_comb begin
        next_steer      = steer;
        next_unlock_key = unlock_key;
        if (flash_store) begin
            next_steer = 1'b0;
        end
        // Software setting the bit in the same cycle re-arms it for the next byte
        if (steer_write) begin
            next_steer = SFR_WDATA_I[STEER_BIT];
        end
        // Only the key nibble of the control byte is writable
        if (XD_WR_I && !steer && XD_ADDR_I == XD_FLASH_CTL) begin
            next_unlock_key = XD_WDATA_I[KEY_LSB +: KEY_W];
        end
    end
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            steer      <= STEER_RST;
            unlock_key <= KEY_RST;
        end else begin
            steer      <= next_steer;
            unlock_key <= next_unlock_key;
        end
    end
    assign STEER_O         = steer;
    assign READ_ALLOWED_O  = !SECURITY_LOCK_LOCK_I;
    assign WRITE_ALLOWED_O = key_ok && !SECURITY_LOCK_LOCK_I;
    ////////////////////////////////////////////////////////////////////////////////
    // Routed store outputs
    logic        next_xram_wr;
    logic        next_flash_wr;
    logic [15:0] next_store_addr;
    logic [7:0]  next_store_data;
    always_comb begin
        next_xram_wr    = xram_store;
        next_flash_wr   = flash_store;
        next_store_addr = STORE_ADDR_O;
        next_store_data = STORE_DATA_O;
        if (xram_store || flash_store) begin
            next_store_addr = XD_ADDR_I;
            next_store_data = XD_WDATA_I;
        end
    end
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            XRAM_WR_O    <= 1'b0;
            FLASH_WR_O   <= 1'b0;
            STORE_ADDR_O <= 16'h0000;
            STORE_DATA_O <= BYTE_ZERO;
        end else begin
            XRAM_WR_O    <= next_xram_wr;
            FLASH_WR_O   <= next_flash_wr;
            STORE_ADDR_O <= next_store_addr;
            STORE_DATA_O <= next_store_data;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt source flags and core pending bits
    logic [SRC_W:0] src_set;
    logic [SRC_W:0] src_clr;
    logic [SRC_W:0] src_flags;
    logic [1:0]     pend_set;
    logic [1:0]     pend_clr;
    logic [1:0]     pend;
    logic           int2_q;
    logic           int6_q;
    // Flags clear on a written 0; a written 1 leaves them alone
    always_comb begin
        src_set = {VPULSE_EVENT_I, SRC_EVENT_I};
        src_clr = '0;
        if (SFR_WR_I && sfr_hit(SFR_ADDR_I, SFR_SRC_FLAGS)) begin
            src_clr[SRC_W-1:0] = ~SFR_WDATA_I;
        end
        if (SFR_WR_I && sfr_hit(SFR_ADDR_I, SFR_VPULSE)) begin
            src_clr[SRC_W] = ~SFR_WDATA_I[VPULSE_BIT];
        end
    end
    faif_flags #(
        .WIDTH (SRC_W + 1)
    ) u_src_flags (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RST_I),
        .set_i   (src_set),
        .clr_i   (src_clr),
        .flags_o (src_flags)
    );
    assign INT2_O = |(src_flags & INT2_MASK);
    assign INT5_O = |(src_flags & INT5_MASK);
    assign INT6_O = |(src_flags & INT6_MASK);
    // Pending bits latch a rising line; new edges beat vector and software clears
    always_comb begin
        pend_set = {INT6_O && !int6_q, INT2_O && !int2_q};
        pend_clr = {VECT6_I, VECT2_I};
        if (SFR_WR_I && sfr_hit(SFR_ADDR_I, SFR_CORE_PEND)) begin
            pend_clr[0] = pend_clr[0] | ~SFR_WDATA_I[PEND2_BIT];
            pend_clr[1] = pend_clr[1] | ~SFR_WDATA_I[PEND6_BIT];
        end
    end
    faif_flags #(
        .WIDTH (2)
    ) u_core_pend (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RST_I),
        .set_i   (pend_set),
        .clr_i   (pend_clr),
        .flags_o (pend)
    );
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            int2_q <= 1'b0;
            int6_q <= 1'b0;
        end else begin
            int2_q <= INT2_O;
            int6_q <= INT6_O;
        end
    end
    assign CORE_PEND2_O = pend[0];
    assign CORE_PEND6_O = pend[1];
    ////////////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the strobe
    logic [7:0] next_sfr_rdata;
    logic [7:0] next_xd_rdata;

    always_comb begin
        next_sfr_rdata = BYTE_ZERO;
        if (SFR_RD_I) begin
            case (SFR_ADDR_I)
                SFR_PROG_STEER: begin
                    next_sfr_rdata[STEER_BIT] = steer;
                    next_sfr_rdata[TPEND_BIT] = TIMED_PEND_I;
                end
                SFR_CORE_PEND: begin
                    next_sfr_rdata[PEND2_BIT] = pend[0];
                    next_sfr_rdata[PEND6_BIT] = pend[1];
                end
                SFR_SRC_FLAGS: next_sfr_rdata = src_flags[SRC_W-1:0];
                SFR_VPULSE:    next_sfr_rdata[VPULSE_BIT] = src_flags[SRC_W];
                default:       next_sfr_rdata = BYTE_ZERO;
            endcase
        end
        next_xd_rdata = BYTE_ZERO;
        if (XD_RD_I && !steer) begin
            case (XD_ADDR_I)
                XD_FLASH_CTL: begin
                    next_xd_rdata[KEY_LSB +: KEY_W] = unlock_key;
                    next_xd_rdata[RDE_BIT]          = READ_ALLOWED_O;
                    next_xd_rdata[WRE_BIT]          = WRITE_ALLOWED_O;
                end
                XD_RAW_INT: next_xd_rdata = {1'b0, RAW_INT_I};
                default:    next_xd_rdata = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SFR_RDATA_O <= BYTE_ZERO;
            XD_RDATA_O  <= BYTE_ZERO;
        end else begin
            SFR_RDATA_O <= next_sfr_rdata;
            XD_RDATA_O  <= next_xd_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sequence store_armed;
        XD_WR_I && steer && key_ok && !TIMED_PEND_I;
    endsequence

    sequence flash_byte_out;
        FLASH_WR_O && !XRAM_WR_O && STORE_ADDR_O == $past(XD_ADDR_I);
    endsequence

    ram_route_a: assert property (xram_store |=> XRAM_WR_O && !FLASH_WR_O)
        else $error("store with steer clear not routed to RAM");
    flash_route_a: assert property (store_armed |=> flash_byte_out)
        else $error("armed store not written to flash");
    steer_clear_a: assert property (store_armed ##0 !steer_write |=> !steer ##1 !FLASH_WR_O)
        else $error("steer bit not cleared after flash byte");
    steer_lock_a: assert property (SFR_WR_I && SFR_ADDR_I == SFR_PROG_STEER && INT_EN_I
                                   && !XD_WR_I |=> $stable(steer))
        else $error("steer bit changed while interrupts enabled");
    read_allow_a: assert property (READ_ALLOWED_O != SECURITY_LOCK_LOCK_I)
        else $error("read permission not inverse of lock");
    key_gate_a: assert property (XD_WR_I && steer && !key_ok && !steer_write
                                 |=> !FLASH_WR_O && steer)
        else $error("flash written without unlock key");
    write_allow_a: assert property (WRITE_ALLOWED_O == (unlock_key == UNLOCK_KEY && !SECURITY_LOCK_LOCK_I))
        else $error("write permission mismatch");
    flag_sticky_a: assert property (src_flags[0] && !src_clr[0] |=> src_flags[0])
        else $error("source flag dropped without clear");
    flag_set_a: assert property (SRC_EVENT_I[0] ##1 1'b1 [*2] |-> src_flags[0] || $past(src_clr[0]))
        else $error("source event not recorded");
    vector_clear_a: assert property (VECT2_I && !pend_set[0] |=> !CORE_PEND2_O)
        else $error("pending two not cleared on vector");
    raw_view_a: assert property (XD_RD_I && !steer && XD_ADDR_I == XD_RAW_INT
                                 |=> XD_RDATA_O == {1'b0, $past(RAW_INT_I)})
        else $error("raw interrupt read mismatch");
    pend_block_a: assert property (XD_WR_I && TIMED_PEND_I |=> !FLASH_WR_O)
        else $error("flash written while timed write pending");
    ro_write_a: assert property (XD_WR_I && XD_ADDR_I == XD_RAW_INT |=> $stable(unlock_key))
        else $error("write to raw field changed state");
endmodule : faif_regs
`default_nettype wire

// [verification/faif_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Core side of both register ports; strobes move on the falling edge only
module faif_core_model
    import faif_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Special-function register side
    output logic      [7:0]  sfr_addr_o,
    output logic      [7:0]  sfr_wdata_o,
    output logic             sfr_wr_o,
    output logic             sfr_rd_o,
    input  wire logic [7:0]  sfr_rdata_i,
    // External-data side
    output logic      [15:0] xd_addr_o,
    output logic      [7:0]  xd_wdata_o,
    output logic             xd_wr_o,
    output logic             xd_rd_o,
    input  wire logic [7:0]  xd_rdata_i
);
    initial begin
        {sfr_addr_o, sfr_wdata_o, sfr_wr_o, sfr_rd_o} = '0;
        {xd_addr_o, xd_wdata_o, xd_wr_o, xd_rd_o} = '0;
    end
    // Released lines flip so a stale address never passes for a live one
    task automatic idle();
        sfr_addr_o  = ~sfr_addr_o;
        sfr_wdata_o = ~sfr_wdata_o;
        xd_addr_o   = ~xd_addr_o;
        xd_wdata_o  = ~xd_wdata_o;
    endtask : idle
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {sfr_addr_o, sfr_wdata_o, sfr_wr_o} = {a, d, 1'b1};
        @(negedge clk_i);
        sfr_wr_o = 1'b0;
        idle();
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {sfr_addr_o, sfr_rd_o} = {a, 1'b1};
        @(negedge clk_i);
        d = sfr_rdata_i;
        sfr_rd_o = 1'b0;
        idle();
    endtask : sfr_rd
    task automatic xd_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        {xd_addr_o, xd_wdata_o, xd_wr_o} = {a, d, 1'b1};
        @(negedge clk_i);
        xd_wr_o = 1'b0;
        idle();
    endtask : xd_wr
    task automatic xd_rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_i);
        {xd_addr_o, xd_rd_o} = {a, 1'b1};
        @(negedge clk_i);
        d = xd_rdata_i;
        xd_rd_o = 1'b0;
        idle();
    endtask : xd_rd
    // Zero at the bit being cleared, ones everywhere else
    task automatic clr_pend(input int b);
        sfr_wr(SFR_CORE_PEND, ~(8'h01 << b));
    endtask : clr_pend
endmodule : faif_core_model
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import faif_pkg::*;
    localparam logic [8:0] M2 = 9'h007;
    localparam logic [8:0] M5 = 9'h0D0;
    localparam logic [8:0] M6 = 9'h128;
    logic        clk = 1'b0, rst = 1'b1, int_en = 1'b0, lock = 1'b0, tpend = 1'b0;
    logic        vect2 = 1'b0, vect6 = 1'b0, vp_ev = 1'b0;
    logic [7:0]  src_ev = 8'h00, d;
    logic [6:0]  raw = 7'h00;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xd_wdata, xd_rdata, st_data;
    logic [15:0] xd_addr, st_addr;
    logic        sfr_wr, sfr_rd, xd_wr, xd_rd, xram_wr, flash_wr, steer, rde, wre;
    logic        i2, i5, i6, p2, p6;
    int          miscompares = 0, num_checks = 0;
    always #25 clk = ~clk;
    faif_core_model core (.clk_i(clk), .sfr_addr_o(sfr_addr), .sfr_wdata_o(sfr_wdata),
        .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd), .sfr_rdata_i(sfr_rdata), .xd_addr_o(xd_addr),
        .xd_wdata_o(xd_wdata), .xd_wr_o(xd_wr), .xd_rd_o(xd_rd), .xd_rdata_i(xd_rdata));
    faif_regs #(.INT2_MASK(M2), .INT5_MASK(M5), .INT6_MASK(M6)) dut (.SYS_CLK_I(clk),
        .RST_I(rst), .SFR_ADDR_I(sfr_addr), .SFR_WDATA_I(sfr_wdata), .SFR_WR_I(sfr_wr),
        .SFR_RD_I(sfr_rd), .SFR_RDATA_O(sfr_rdata), .XD_ADDR_I(xd_addr), .XD_WDATA_I(xd_wdata),
        .XD_WR_I(xd_wr), .XD_RD_I(xd_rd), .XD_RDATA_O(xd_rdata), .XRAM_WR_O(xram_wr),
        .FLASH_WR_O(flash_wr), .STORE_ADDR_O(st_addr), .STORE_DATA_O(st_data),
        .INT_EN_I(int_en), .VECT2_I(vect2), .VECT6_I(vect6), .SECURITY_LOCK_LOCK_I(lock),
        .TIMED_PEND_I(tpend), .SRC_EVENT_I(src_ev), .VPULSE_EVENT_I(vp_ev), .RAW_INT_I(raw),
        .STEER_O(steer), .READ_ALLOWED_O(rde), .WRITE_ALLOWED_O(wre), .INT2_O(i2),
        .INT5_O(i5), .INT6_O(i6), .CORE_PEND2_O(p2), .CORE_PEND6_O(p6));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("steer", steer, 1'b0);
        core.xd_rd(XD_FLASH_CTL, d);
        chk("ctl", d, 8'h04);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_flash();
        int_en = 1'b1;
        core.sfr_wr(SFR_PROG_STEER, 8'h01);
        chk("steer_ie", steer, 1'b0);
        int_en = 1'b0;
        core.xd_wr(16'h1234, 8'hA5);
        chk("ram", {xram_wr, flash_wr, st_addr, st_data}, {2'b10, 16'h1234, 8'hA5});
        core.sfr_wr(SFR_PROG_STEER, 8'h01);
        core.xd_wr(16'h0100, 8'h3C);
        chk("nokey", {xram_wr, flash_wr, steer}, 3'b001);
        core.sfr_wr(SFR_PROG_STEER, 8'h00);
        core.xd_wr(XD_FLASH_CTL, {UNLOCK_KEY, 4'h0});
        core.sfr_wr(SFR_PROG_STEER, 8'h01);
        core.sfr_rd(SFR_PROG_STEER, d);
        chk("steer_rd", d, 8'h01);
        core.xd_wr(16'h0100, 8'h3C);
        chk("flash", {xram_wr, flash_wr, st_addr, st_data}, {2'b01, 16'h0100, 8'h3C});
        chk("steer_clr", steer, 1'b0);
        core.sfr_wr(SFR_PROG_STEER, 8'h01);
        tpend = 1'b1;
        core.xd_wr(16'h0101, 8'h11);
        chk("pend", {xram_wr, flash_wr, steer}, 3'b001);
        tpend = 1'b0;
        core.sfr_wr(SFR_PROG_STEER, 8'h00);
        $display("t_flash done");
    endtask : t_flash
    task automatic t_key();
        core.xd_wr(XD_FLASH_CTL, 8'hF6);
        chk("ro_ram", xram_wr, 1'b0);
        core.xd_rd(XD_FLASH_CTL, d);
        chk("key_f", d, 8'hF4);
        core.xd_wr(XD_FLASH_CTL, {UNLOCK_KEY, 4'h0});
        core.xd_rd(XD_FLASH_CTL, d);
        chk("key_2", d, 8'h26);
        lock = 1'b1;
        @(negedge clk);
        chk("locked", {rde, wre}, 2'b00);
        lock = 1'b0;
        for (int k = 0; k < 2; k++) begin
            raw = k ? 7'h2A : 7'h55;
            core.xd_rd(XD_RAW_INT, d);
            chk("raw", d, {1'b0, raw});
        end
        core.xd_wr(XD_RAW_INT, 8'h00);
        chk("raw_ram", xram_wr, 1'b0);
        core.xd_rd(XD_RAW_INT, d);
        chk("raw_wr", {xram_wr, d}, 9'h02A);
        $display("t_key done");
    endtask : t_key
    task automatic t_flags();
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            if (i < 8) src_ev[i] = 1'b1;
            else vp_ev = 1'b1;
            @(negedge clk);
            src_ev = 8'h00;
            vp_ev  = 1'b0;
            chk("lines", {i2, i5, i6}, {M2[i], M5[i], M6[i]});
            core.sfr_rd(i < 8 ? SFR_SRC_FLAGS : SFR_VPULSE, d);
            chk("flag", d, i < 8 ? 8'h01 << i : 8'h08);
            if (i < 8) core.sfr_wr(SFR_SRC_FLAGS, ~(8'h01 << i));
            else core.sfr_wr(SFR_VPULSE, 8'hF7);
            chk("flag_clr", {i2, i5, i6}, 3'b000);
        end
        $display("t_flags done");
    endtask : t_flags
    task automatic t_pend();
        core.sfr_rd(SFR_CORE_PEND, d);
        chk("pend_rd", d, 8'h22);
        @(negedge clk);
        {vect2, vect6} = 2'b11;
        @(negedge clk);
        {vect2, vect6} = 2'b00;
        chk("vect", {p2, p6}, 2'b00);
        src_ev = 8'h09;
        @(negedge clk);
        src_ev = 8'h00;
        repeat (2) @(negedge clk);
        chk("pend_set", {p2, p6}, 2'b11);
        core.clr_pend(PEND2_BIT);
        chk("clr2", {p2, p6}, 2'b01);
        core.clr_pend(PEND6_BIT);
        chk("clr6", {p2, p6}, 2'b00);
        $display("t_pend done");
    endtask : t_pend
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_flash();
        t_key();
        t_flags();
        t_pend();
        end_of_test();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
